//--- rtl/monitor_irq_map.vh
// register map, reset values and timing counts of the monitor interrupt block
`ifndef MONITOR_IRQ_MAP_VH
`define MONITOR_IRQ_MAP_VH
`define CFG_IDX          8'h00
`define FLAGS_ONE_IDX    8'h01
`define FLAGS_TWO_IDX    8'h02
`define BLOCK_ONE_IDX    8'h03
`define BLOCK_TWO_IDX    8'h04
`define OUTSEL_IDX       8'h05
`define OTCFG_IDX        8'h06
`define CONV_RATE_IDX    8'h07
`define CHAN_DIS_IDX     8'h08
`define EVENTS_IDX       8'h10
`define CFG_RST          8'h08
`define FLAGS_RST        8'h00
`define BLOCK_RST        8'h00
`define OUTSEL_RST       8'h14
`define OTCFG_RST        8'h01
`define CONV_RATE_RST    8'h00
`define CHAN_DIS_RST     8'h00
`define CFG_START        0
`define CFG_INT_EN       1
`define CFG_POL          2
`define CFG_HOLD         3
`define CFG_RESET        4
`define CFG_CASE_CLR     5
`define CFG_PWR          6
`define CFG_INIT         7
`define F1_CHAIN         7
`define F2_HOT           0
`define F2_BTA           1
`define F2_CASE          4
`define F2_OT            5
`define OUTSEL_OT_EN     6
`define OUTSEL_RST_EN    7
`define OTCFG_ONETIME    2
`define PULSE_MS         10
`define CLK_MHZ          125
`define PULSE_CYCLES     (`PULSE_MS * 1000 * `CLK_MHZ)
`endif

//--- rtl/monitor_irq.v
// interrupt collection and output control of a hardware monitor, apb slave
// ---------------------------------------------------------------------------
// Functional notes
// - low board temperature alert sets bit 1 of second flag register
// - bit 1 of second block register keeps board alert off interrupt
// - case open input flags bit 4 of flags two; block two bit 4 masks
// - config bit 5 pulls case line low at least 10 ms, then self-clears
// - low chained interrupt input sets bit 7 of first flag register
// - with config bit 1 set, chained low also asserts interrupt output
// - bit 7 of first block register masks chained input from interrupt
// - interrupt active on any unmasked source, only if config bit 1 set
// - config bit 2 sets polarity, bit 3 holds interrupt inactive
// - polarity one: active-high open source; zero: active-low open drain
// - shared pin is overtemp output only when select bit 6 high, bit 7 low
// - overtemp pin one-time mode if temp config bit 2, else comparator
// - overtemp flag bit 5 default or one-time; masked by block two bit 5
// - reading a flag register returns it then clears it
// - after clearing read, flag interrupt drops until loop updates flags again; unmasked chained low keeps it active
// - hold bit drops interrupt output, flag contents unchanged
// - while hold bit is high the monitoring loop stops
// - config bit 6 drives the power control output low
// - reset pulse on shared pin only when select bit 7 is high
// - config bit 4 gives active-low pulse of at least 10 ms, then clears
// - low tree test select enters nand tree mode, tree out on address pin
// - eight-bit pointer, zero at reset, records the register index of each access except a config write with bit 7 set
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
`include "monitor_irq_map.vh"
module monitor_irq #(
  parameter PULSE_CYCLES = `PULSE_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        board_temp_alert_n,
  input  wire        case_open_input,
  input  wire        chain_irq_n,
  input  wire        tree_test_select_n,
  input  wire [7:0]  tree_inputs,
  input  wire [6:0]  limit_events_one,
  input  wire [2:0]  limit_events_two,
  input  wire        hot_event,
  input  wire        ot_event,
  input  wire        ot_active,
  output reg         irq_out,
  output reg         irq_oe,
  output reg         case_clear_out,
  output reg         case_clear_oe,
  output reg         shared_out,
  output reg         shared_oe,
  output reg         power_ctrl_out,
  output reg         power_ctrl_oe,
  output reg         tree_test_out,
  output reg         tree_test_oe,
  output reg         monitor_run,
  output reg  [7:0]  pointer_out
);

  // ---------------------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------------------
  localparam NSYNC = 12;
  wire [NSYNC-1:0] raw_in = {tree_inputs, tree_test_select_n, chain_irq_n,
                             case_open_input, board_temp_alert_n};
  reg  [NSYNC-1:0] sync1_reg;
  reg  [NSYNC-1:0] sync2_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= {NSYNC{1'b1}};
      sync2_reg <= {NSYNC{1'b1}};
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end
  wire       bta_n_s   = sync2_reg[0];
  wire       case_s    = sync2_reg[1];
  wire       chain_n_s = sync2_reg[2];
  wire       tsel_n_s  = sync2_reg[3];
  wire [7:0] tree_s    = sync2_reg[11:4];

  // ---------------------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------------------
  reg  [7:0] cfg_reg;
  reg  [7:0] flags_one_reg;
  reg  [7:0] flags_two_reg;
  reg  [7:0] block_one_reg;
  reg  [7:0] block_two_reg;
  reg  [7:0] outsel_reg;
  reg  [7:0] otcfg_reg;
  reg  [7:0] conv_rate_reg;
  reg  [7:0] chan_dis_reg;
  reg  [7:0] pointer_reg;
  reg  [7:0] rdata_next;
  reg        hit_next;

  wire       setup  = psel && !penable;
  wire       access = psel && penable && pready;
  wire       wr     = access && pwrite && !pslverr;
  wire       rd     = access && !pwrite && !pslverr;
  wire [7:0] idx    = paddr[9:2];
  wire       align  = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h00_0000);
  wire [7:0] wbyte  = pwdata[7:0];

  always @* begin
    hit_next   = align;
    rdata_next = 8'h00;
    if (idx == `CFG_IDX) begin
      rdata_next = cfg_reg;
    end else if (idx == `FLAGS_ONE_IDX) begin
      rdata_next = flags_one_reg;
    end else if (idx == `FLAGS_TWO_IDX) begin
      rdata_next = flags_two_reg;
    end else if (idx == `BLOCK_ONE_IDX) begin
      rdata_next = block_one_reg;
    end else if (idx == `BLOCK_TWO_IDX) begin
      rdata_next = block_two_reg;
    end else if (idx == `OUTSEL_IDX) begin
      rdata_next = outsel_reg;
    end else if (idx == `OTCFG_IDX) begin
      rdata_next = otcfg_reg;
    end else if (idx == `CONV_RATE_IDX) begin
      rdata_next = conv_rate_reg;
    end else if (idx == `CHAN_DIS_IDX) begin
      rdata_next = chan_dis_reg;
    end else if (idx == `EVENTS_IDX) begin
      rdata_next = pointer_reg;
    end else begin
      hit_next = 1'b0;
    end
  end

  // no wait state: answer registered at setup, access completes next edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= !hit_next;
      prdata  <= {24'h00_0000, hit_next ? rdata_next : 8'h00};
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  wire wr_cfg = wr && idx == `CFG_IDX;
  wire init   = wr_cfg && wbyte[`CFG_INIT];
  wire rd_f1  = rd && idx == `FLAGS_ONE_IDX;
  wire rd_f2  = rd && idx == `FLAGS_TWO_IDX;

  // ---------------------------------------------------------------------------
  // pulse timers
  // ---------------------------------------------------------------------------
  reg  [20:0] case_cnt_reg;
  reg  [20:0] rst_cnt_reg;
  wire        case_done = case_cnt_reg == PULSE_CYCLES[20:0];
  wire        rst_done  = rst_cnt_reg == PULSE_CYCLES[20:0];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      case_cnt_reg <= 21'h00_0000;
      rst_cnt_reg  <= 21'h00_0000;
    end else begin
      case_cnt_reg <= cfg_reg[`CFG_CASE_CLR] && !case_done ? case_cnt_reg + 21'h00_0001
                                                          : 21'h00_0000;
      rst_cnt_reg  <= cfg_reg[`CFG_RESET] && !rst_done ? rst_cnt_reg + 21'h00_0001
                                                      : 21'h00_0000;
    end
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  // the loop update stands still under hold so no flag sets while held
  wire       loop_go = !cfg_reg[`CFG_HOLD] && cfg_reg[`CFG_START];
  reg  [7:0] ev_one;
  reg  [7:0] ev_two;
  reg        updated_reg;
  always @* begin
    ev_one = {!chain_n_s, limit_events_one};
    ev_two = {2'b00, ot_event, case_s, limit_events_two[2:1], !bta_n_s,
              hot_event};
    if (!loop_go) begin
      ev_one = 8'h00;
      ev_two = 8'h00;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg       <= `CFG_RST;
      flags_one_reg <= `FLAGS_RST;
      flags_two_reg <= `FLAGS_RST;
      block_one_reg <= `BLOCK_RST;
      block_two_reg <= `BLOCK_RST;
      outsel_reg    <= `OUTSEL_RST;
      otcfg_reg     <= `OTCFG_RST;
      conv_rate_reg <= `CONV_RATE_RST;
      chan_dis_reg  <= `CHAN_DIS_RST;
      pointer_reg   <= 8'h00;
      updated_reg   <= 1'b0;
    end else if (init) begin
      cfg_reg       <= `CFG_RST;
      flags_one_reg <= `FLAGS_RST;
      flags_two_reg <= `FLAGS_RST;
      block_one_reg <= `BLOCK_RST;
      block_two_reg <= `BLOCK_RST;
      outsel_reg    <= `OUTSEL_RST;
      otcfg_reg     <= `OTCFG_RST;
      conv_rate_reg <= `CONV_RATE_RST;
      chan_dis_reg  <= `CHAN_DIS_RST;
      updated_reg   <= 1'b0;
    end else begin
      if (access) begin
        pointer_reg <= idx;
      end
      if (wr_cfg) begin
        cfg_reg <= {1'b0, wbyte[6:0]};
      end else begin
        if (case_done) begin
          cfg_reg[`CFG_CASE_CLR] <= 1'b0;
        end
        if (rst_done) begin
          cfg_reg[`CFG_RESET] <= 1'b0;
        end
      end
      // set wins over the clearing read
      flags_one_reg <= (rd_f1 ? 8'h00 : flags_one_reg) | ev_one;
      flags_two_reg <= ((rd_f2 ? 8'h00 : flags_two_reg) | ev_two) & 8'h3f;
      if (rd_f1 || rd_f2) begin
        updated_reg <= 1'b0;
      end else if ((ev_one | ev_two) != 8'h00) begin
        updated_reg <= 1'b1;
      end
      if (wr && idx == `BLOCK_ONE_IDX) begin
        block_one_reg <= wbyte;
      end
      if (wr && idx == `BLOCK_TWO_IDX) begin
        block_two_reg <= wbyte;
      end
      if (wr && idx == `OUTSEL_IDX) begin
        outsel_reg <= wbyte;
      end
      if (wr && idx == `OTCFG_IDX) begin
        otcfg_reg <= wbyte;
      end
      if (wr && idx == `CONV_RATE_IDX) begin
        conv_rate_reg <= wbyte;
      end
      if (wr && idx == `CHAN_DIS_IDX) begin
        chan_dis_reg <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // overtemp pin state
  // ---------------------------------------------------------------------------
  reg ot_latch_reg;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ot_latch_reg <= 1'b0;
    end else if (otcfg_reg[`OTCFG_ONETIME]) begin
      // one-time: latched by the event, released by a read of flags two
      ot_latch_reg <= ot_event ? 1'b1 : (rd_f2 ? 1'b0 : ot_latch_reg);
    end else begin
      ot_latch_reg <= ot_active;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  wire pend_one = (flags_one_reg & ~block_one_reg) != 8'h00;
  wire pend_two = (flags_two_reg & ~block_two_reg) != 8'h00;
  wire chain_live = !chain_n_s && !block_one_reg[`F1_CHAIN];
  wire irq_act = cfg_reg[`CFG_INT_EN] && !cfg_reg[`CFG_HOLD] &&
                 ((updated_reg && (pend_one || pend_two)) || chain_live);
  wire ot_mode  = outsel_reg[`OUTSEL_OT_EN] && !outsel_reg[`OUTSEL_RST_EN];
  wire rst_mode = outsel_reg[`OUTSEL_RST_EN];
  wire tree_nand = ~&tree_s;
  reg  tree_par_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out        <= 1'b0;
      irq_oe         <= 1'b0;
      case_clear_out <= 1'b0;
      case_clear_oe  <= 1'b0;
      shared_out     <= 1'b0;
      shared_oe      <= 1'b0;
      power_ctrl_out <= 1'b0;
      power_ctrl_oe  <= 1'b0;
      tree_test_out  <= 1'b0;
      tree_test_oe   <= 1'b0;
      tree_par_reg   <= 1'b0;
      monitor_run    <= 1'b0;
      pointer_out    <= 8'h00;
    end else begin
      // open drain drives only low, open source only high
      irq_out        <= cfg_reg[`CFG_POL];
      irq_oe         <= irq_act;
      case_clear_out <= 1'b0;
      case_clear_oe  <= cfg_reg[`CFG_CASE_CLR];
      shared_out     <= 1'b0;
      shared_oe      <= rst_mode ? cfg_reg[`CFG_RESET] : (ot_mode && ot_latch_reg);
      power_ctrl_out <= 1'b0;
      power_ctrl_oe  <= cfg_reg[`CFG_PWR];
      // a single nand gate over all tree pins toggles on a single pin toggle while all other pins are high
      tree_par_reg   <= tree_nand;
      tree_test_out  <= tree_par_reg;
      tree_test_oe   <= !tsel_n_s;
      monitor_run    <= loop_go;
      pointer_out    <= pointer_reg;
    end
  end

endmodule

//--- verif/alert_sources.sv
// model of the external alert sources and tree pin drivers around the monitor
`timescale 1ns/10ps
module alert_sources (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       want_bta,
  input  wire       want_case,
  input  wire       want_chain,
  input  wire [7:0] tree_drive,
  input  wire       case_clear_out,
  input  wire       case_clear_oe,
  output wire       board_temp_alert_n,
  output wire       case_open_input,
  output wire       chain_irq_n,
  output wire [7:0] tree_inputs
);
  // ------------------------
  // external intrusion latch
  // ------------------------
  reg case_latch_reg;
  // latch keeps the event until the monitor pulls the line low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      case_latch_reg <= 1'b0;
    else if (case_clear_oe)
      case_latch_reg <= 1'b0;
    else if (want_case)
      case_latch_reg <= 1'b1;
  end
  assign case_open_input    = case_clear_oe ? case_clear_out : case_latch_reg;
  // pulled-up alert lines: released means high
  assign board_temp_alert_n = !want_bta;
  assign chain_irq_n        = !want_chain;
  assign tree_inputs        = tree_drive;
endmodule

//--- verif/monitor_irq_checker.sv
// assertion checker on the monitor interrupt block ports
`timescale 1ns/10ps
module monitor_irq_checker #(
  parameter PULSE_CYCLES = 20
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        tree_test_select_n,
  input wire        irq_out,
  input wire        irq_oe,
  input wire        case_clear_oe,
  input wire        power_ctrl_oe,
  input wire        tree_test_oe
);
  // ------------------------------
  // shadow config and pulse length
  // ------------------------------
  reg [7:0]  cfg_q;
  reg [31:0] clr_cnt;
  // self-clearing bits are not tracked, only the static ones are used
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q   <= 8'h08;
      clr_cnt <= 32'h0000_0000;
    end else begin
      if (psel && penable && pready && pwrite && paddr == 32'h0000_0000)
        cfg_q <= pwdata[7:0];
      clr_cnt <= case_clear_oe ? clr_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_bad_addr_err: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access not refused");
  a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_irq_needs_enable: assert property (!cfg_q[1] && !$past(cfg_q[1]) |-> !irq_oe)
    else $error("interrupt while disabled");
  a_hold_quiets_irq: assert property (cfg_q[3] && $past(cfg_q[3]) |-> !irq_oe)
    else $error("interrupt while held");
  a_polarity_level: assert property (irq_oe && cfg_q[2] == $past(cfg_q[2])
    |-> irq_out == cfg_q[2])
    else $error("interrupt level wrong");
  a_power_follows: assert property (cfg_q[6] == $past(cfg_q[6])
    |-> power_ctrl_oe == cfg_q[6])
    else $error("power output mismatch");
  a_clear_pulse_len: assert property ($fell(case_clear_oe) |-> clr_cnt == PULSE_CYCLES + 1)
    else $error("case clear pulse length wrong");
  a_tree_mode_entry: assert property ($fell(tree_test_select_n) |-> ##[1:5] tree_test_oe)
    else $error("tree mode not entered");
  c_irq: cover property (irq_oe);
  c_clear_pulse: cover property ($fell(case_clear_oe));
  c_refused: cover property (pready && pslverr);
endmodule

//--- verif/monitor_irq_test.sv
// self-checking testbench of the monitor interrupt block
`timescale 1ns/10ps
`include "monitor_irq_map.vh"
module monitor_irq_test;
  localparam PULSE_CYCLES = 20;
  reg         pclk, presetn, psel, penable, pwrite, tree_test_select_n;
  reg  [31:0] paddr, pwdata;
  reg         want_bta, want_case, want_chain, last_err, ot_ev_drv, ot_act_drv;
  reg  [7:0]  tree_drive, last_rd;
  wire [31:0] prdata;
  wire        pready, pslverr, board_temp_alert_n, case_open_input, chain_irq_n;
  wire        irq_out, irq_oe, case_clear_out, case_clear_oe, shared_out, shared_oe;
  wire        power_ctrl_out, power_ctrl_oe, tree_test_out, tree_test_oe, monitor_run;
  wire [7:0]  tree_inputs, pointer_out;
  int         fail_count, n_compared, clr_hi, sh_hi;
  monitor_irq #(.PULSE_CYCLES(PULSE_CYCLES)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .board_temp_alert_n, .case_open_input,
    .chain_irq_n, .tree_test_select_n, .tree_inputs, .limit_events_one(7'h00),
    .limit_events_two(3'h0), .hot_event(1'b0), .ot_event(ot_ev_drv), .ot_active(ot_act_drv),
    .irq_out,
    .irq_oe, .case_clear_out, .case_clear_oe, .shared_out, .shared_oe, .power_ctrl_out,
    .power_ctrl_oe, .tree_test_out, .tree_test_oe, .monitor_run, .pointer_out);
  alert_sources far_side (.pclk, .presetn, .want_bta, .want_case, .want_chain, .tree_drive,
    .case_clear_out, .case_clear_oe, .board_temp_alert_n, .case_open_input, .chain_irq_n,
    .tree_inputs);
  // -----------------
  // clock and helpers
  // -----------------
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (case_clear_oe === 1'b1) clr_hi++;
    if (shared_oe === 1'b1) sh_hi++;
  end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer, then one idle cycle so psel never toggles twice in a step
  task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      close_out;
    end
    last_rd = prdata[7:0];
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, {22'h0, idx, 2'b00}, d);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, {22'h0, idx, 2'b00}, 8'h00);
    check(last_rd, exp);
  endtask
  task automatic bta_pulse;
    want_bta <= 1'b1;
    cyc(6);
    want_bta <= 1'b0;
    cyc(4);
  endtask
  task automatic wait_low(input logic sel);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (((sel ? sh_hi : clr_hi) == 0 || (sel ? shared_oe : case_clear_oe) !== 1'b0)
               && n < 300);
    if (n >= 300) begin
      fail_count++;
      close_out;
    end
  endtask
  // ---------
  // scenarios
  // ---------
  task automatic s_regs;
    logic [7:0] rv [0:8];
    rv = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h14, 8'h01, 8'h00, 8'h00};
    for (int i = 0; i < 9; i++)
      rd(i[7:0], rv[i]);
    rd(8'h09, 8'h00);
    check(last_err, 1'b1);
    apb(1'b0, 32'h0000_0006, 8'h00);
    check(last_err, 1'b1);
    wr(`BLOCK_TWO_IDX, 8'hA5);
    rd(`BLOCK_TWO_IDX, 8'hA5);
    wr(`BLOCK_TWO_IDX, 8'h00);
    cyc(1);
    check(pointer_out, {24'h00_0000, `BLOCK_TWO_IDX});
  endtask
  task automatic s_alerts;
    wr(`CFG_IDX, 8'h03);
    bta_pulse;
    check(irq_oe, 1'b1);
    check(irq_out, 1'b0);
    rd(`FLAGS_TWO_IDX, 8'h02);
    rd(`FLAGS_TWO_IDX, 8'h00);
    check(irq_oe, 1'b0);
    wr(`BLOCK_TWO_IDX, 8'h02);
    bta_pulse;
    check(irq_oe, 1'b0);
    rd(`FLAGS_TWO_IDX, 8'h02);
    wr(`BLOCK_TWO_IDX, 8'h00);
    want_case <= 1'b1;
    cyc(2);
    want_case <= 1'b0;
    cyc(4);
    check(irq_oe, 1'b1);
    rd(`FLAGS_TWO_IDX, 8'h10);
    clr_hi = 0;
    wr(`CFG_IDX, 8'h23);
    wait_low(1'b0);
    check(clr_hi, PULSE_CYCLES + 1);
    rd(`CFG_IDX, 8'h03);
    rd(`FLAGS_TWO_IDX, 8'h10);
    rd(`FLAGS_TWO_IDX, 8'h00);
  endtask
  task automatic s_chain_hold;
    want_chain <= 1'b1;
    cyc(4);
    check(irq_oe, 1'b1);
    wr(`BLOCK_ONE_IDX, 8'h80);
    cyc(2);
    check(irq_oe, 1'b0);
    want_chain <= 1'b0;
    cyc(4);
    rd(`FLAGS_ONE_IDX, 8'h80);
    wr(`BLOCK_ONE_IDX, 8'h00);
    bta_pulse;
    wr(`CFG_IDX, 8'h0B);
    cyc(2);
    check(irq_oe, 1'b0);
    check(monitor_run, 1'b0);
    rd(`FLAGS_TWO_IDX, 8'h02);
    bta_pulse;
    rd(`FLAGS_TWO_IDX, 8'h00);
    wr(`CFG_IDX, 8'h47);
    bta_pulse;
    check(irq_oe, 1'b1);
    check(irq_out, 1'b1);
    check(power_ctrl_oe, 1'b1);
    check(power_ctrl_out, 1'b0);
    rd(`FLAGS_TWO_IDX, 8'h02);
  endtask
  task automatic s_pulses;
    sh_hi = 0;
    wr(`CFG_IDX, 8'h13);
    cyc(30);
    check(sh_hi, 0);
    wr(`CFG_IDX, 8'h03);
    wr(`OUTSEL_IDX, 8'h94);
    wr(`CFG_IDX, 8'h13);
    wait_low(1'b1);
    check(sh_hi, PULSE_CYCLES + 1);
    rd(`CFG_IDX, 8'h03);
  endtask
  task automatic s_overtemp;
    wr(`OUTSEL_IDX, 8'h54);
    ot_act_drv <= 1'b1;
    cyc(3);
    check(shared_oe, 1'b1);
    ot_act_drv <= 1'b0;
    cyc(3);
    check(shared_oe, 1'b0);
    wr(`OTCFG_IDX, 8'h05);
    ot_ev_drv <= 1'b1;
    cyc(1);
    ot_ev_drv <= 1'b0;
    cyc(3);
    check(shared_oe, 1'b1);
    check(irq_oe, 1'b1);
    rd(`FLAGS_TWO_IDX, 8'h20);
    cyc(2);
    check(shared_oe, 1'b0);
    check(irq_oe, 1'b0);
  endtask
  task automatic s_tree;
    tree_test_select_n <= 1'b0;
    cyc(8);
    check(tree_test_oe, 1'b1);
    check(tree_test_out, 1'b0);
    for (int i = 0; i < 8; i++) begin
      tree_drive <= ~(8'h01 << i);
      cyc(8);
      check(tree_test_out, 1'b1);
      tree_drive <= 8'hFF;
      cyc(8);
      check(tree_test_out, 1'b0);
    end
    tree_test_select_n <= 1'b1;
  endtask
  initial begin
    {psel, penable, pwrite, want_bta, want_case, want_chain} = 6'h00;
    ot_ev_drv = 1'b0;
    ot_act_drv = 1'b0;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    tree_drive = 8'hFF;
    tree_test_select_n = 1'b1;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(3);
    s_regs;
    s_alerts;
    s_chain_hold;
    s_pulses;
    s_overtemp;
    s_tree;
    close_out;
  end
endmodule
bind monitor_irq monitor_irq_checker #(.PULSE_CYCLES(PULSE_CYCLES)) chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .tree_test_select_n, .irq_out,
  .irq_oe, .case_clear_oe, .power_ctrl_oe, .tree_test_oe);
